/* File: design/mrd_rx_control.sv */
// mrd_rx_control: receive dma control of a single-port ethernet mac.
// assumes frames arrive one byte a cycle from the mac, a dma engine
// consumes packed words and burst requests, and an apb master.
`timescale 1ns/1ps
module mrd_rx_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_last,
   input wire logic full_duplex,
   input wire logic pause_valid,
   input wire logic [15:0] pause_quanta,
   input wire logic [10:0] buf_words,
   input wire logic dma_ack,
   output logic dma_req,
   output logic [10:0] dma_len,
   output logic word_valid,
   output logic [31:0] word_data,
   output logic frame_done,
   output logic frame_drop,
   output logic [1:0] desc_shift,
   output logic tx_hold
);
   import mrd_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl;
      mrd_run_e run_st;
      mrd_dma_e dma_st;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic in_frame;
      logic accept;
      logic [15:0] bcnt;
      logic [15:0] ethtype;
      logic [3:0] ihl;
      logic [15:0] totlen;
      logic [7:0] proto;
      logic [7:0] hi_byte;
      logic [31:0] hdr_sum;
      logic [31:0] l4_sum;
      logic ck_zero;
      logic [31:0] pack;
      logic [1:0] lane;
      logic word_valid;
      logic [31:0] word_data;
      logic frame_done;
      logic frame_drop;
      logic [1:0] desc_shift;
      logic [15:0] drop_cnt;
      logic dma_req;
      logic [10:0] dma_len;
   } mrd_s;

   mrd_s st;
   mrd_s next_st;
   logic pause_hold;

   // ones' complement fold of a wide sum down to 16 bits
   function automatic logic [15:0] fold(input logic [31:0] x);
      logic [31:0] s;
      s = {16'h0000, x[15:0]} + {16'h0000, x[31:16]};
      s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
      return s[15:0];
   endfunction

   function automatic logic sum_ok(input logic [31:0] x);
      return fold(x) == 16'hffff;
   endfunction

   function automatic logic [10:0] burst_len(input logic [5:0] lim,
                                             input logic [10:0] avail);
      logic [10:0] l;
      l = {5'h00, lim};
      if (lim == 6'h00 || avail < l) begin
         return avail;
      end
      return l;
   endfunction

   always_comb begin
      logic apb_done;
      logic take;
      logic first;
      logic [15:0] b;
      logic [15:0] hl;
      logic [15:0] l4_end;
      logic [31:0] hsum;
      logic [31:0] lsum;
      logic [31:0] pseudo;
      logic is_ip;
      logic bad;
      logic zero;
      logic [31:0] pk;
      logic [1:0] ln;
      next_st = st;
      apb_done = 1'b0;
      take = 1'b0;
      first = 1'b0;
      b = 16'h0000;
      hl = 16'h0000;
      l4_end = 16'h0000;
      hsum = 32'h0000_0000;
      lsum = 32'h0000_0000;
      pseudo = 32'h0000_0000;
      is_ip = 1'b0;
      bad = 1'b0;
      zero = 1'b0;
      pk = 32'h0000_0000;
      ln = 2'h0;
      next_st.word_valid = 1'b0;
      next_st.frame_done = 1'b0;
      next_st.frame_drop = 1'b0;

      // apb: one wait state, write lands at the edge pready is seen
      next_st.pready = psel && penable && !st.pready;
      apb_done = psel && penable && st.pready;
      if (psel && penable && !st.pready) begin
         next_st.pslverr = 1'b0;
         next_st.prdata = 32'h0000_0000;
         case (paddr)
            MRD_CTRL_OFF: next_st.prdata = st.ctrl;
            MRD_STAT_OFF: next_st.prdata = {st.drop_cnt, 11'h000,
               pause_hold, st.in_frame, st.run_st};
            default: next_st.pslverr = 1'b1;
         endcase
      end
      if (apb_done && pwrite && paddr == MRD_CTRL_OFF) begin
         next_st.ctrl = pwdata & MRD_CTRL_WMASK;
      end

      // frame reception
      first = rx_valid && !st.in_frame;
      take = rx_valid && (first ? (st.run_st == MRD_ST_RUN) : st.accept);
      if (rx_valid) begin
         next_st.in_frame = !rx_last;
         if (first) begin
            next_st.accept = take;
         end
      end
      b = first ? 16'h0000 : st.bcnt;
      hl = {10'h000, st.ihl, 2'b00};
      l4_end = MRD_L2_LEN + st.totlen;
      hsum = first ? 32'h0000_0000 : st.hdr_sum;
      lsum = first ? 32'h0000_0000 : st.l4_sum;
      zero = first ? 1'b1 : st.ck_zero;
      is_ip = (st.ethtype == MRD_ETH_IPV4);
      if (take) begin
         next_st.bcnt = b + 16'h0001;
         if (!b[0]) begin
            next_st.hi_byte = rx_byte;
         end
         if (b == MRD_OFF_TYPE) begin
            next_st.ethtype[15:8] = rx_byte;
         end
         if (b == MRD_OFF_TYPE + 16'h0001) begin
            next_st.ethtype[7:0] = rx_byte;
         end
         if (b == MRD_OFF_IHL) begin
            next_st.ihl = rx_byte[3:0];
            hl = {10'h000, rx_byte[3:0], 2'b00};
         end
         if (b == MRD_OFF_TLEN) begin
            next_st.totlen[15:8] = rx_byte;
         end
         if (b == MRD_OFF_TLEN + 16'h0001) begin
            next_st.totlen[7:0] = rx_byte;
         end
         if (b == MRD_OFF_PROTO) begin
            next_st.proto = rx_byte;
         end
         if (b[0] && b > MRD_OFF_IHL && b < MRD_L2_LEN + hl) begin
            hsum = hsum + {16'h0000, st.hi_byte, rx_byte};
         end
         // source and destination addresses join the pseudo header
         if (b[0] && b > MRD_OFF_SRC && b <= MRD_OFF_DST_END) begin
            lsum = lsum + {16'h0000, st.hi_byte, rx_byte};
         end
         if (b >= MRD_L2_LEN + hl && b < l4_end) begin
            if (b[0]) begin
               lsum = lsum + {16'h0000, st.hi_byte, rx_byte};
            end else if (b == l4_end - 16'h0001) begin
               lsum = lsum + {16'h0000, rx_byte, 8'h00};
            end
            if ((b == MRD_L2_LEN + hl + MRD_OFF_UDP_CK ||
                 b == MRD_L2_LEN + hl + MRD_OFF_UDP_CK + 16'h0001) &&
                rx_byte != 8'h00) begin
               zero = 1'b0;
            end
         end
         next_st.hdr_sum = hsum;
         next_st.l4_sum = lsum;
         next_st.ck_zero = zero;

         // little-endian word packing; the pad moves the ip header
         // onto a word boundary
         pk = first ? 32'h0000_0000 : st.pack;
         ln = st.lane;
         if (first) begin
            ln = st.ctrl[MRD_ALIGN_BIT] ? MRD_ALIGN_PAD : 2'h0;
            next_st.desc_shift = ln;
         end
         pk[{ln, 3'b000} +: 8] = rx_byte;
         next_st.pack = pk;
         next_st.lane = ln + 2'h1;
         if (ln == 2'h3 || rx_last) begin
            next_st.word_valid = 1'b1;
            next_st.word_data = pk;
            next_st.pack = 32'h0000_0000;
         end

         if (rx_last) begin
            pseudo = {24'h000000, st.proto} +
               {16'h0000, st.totlen - hl};
            // only ipv4 frames are judged; the l4 sums only when the protocol matches
            if (st.ctrl[MRD_IP_BIT] && is_ip && !sum_ok(hsum)) begin
               bad = 1'b1;
            end
            if (st.ctrl[MRD_TCP_BIT] && is_ip &&
                st.proto == MRD_PROTO_TCP && !sum_ok(lsum + pseudo)) begin
               bad = 1'b1;
            end
            // a zero udp checksum means the sender did not compute one
            if (st.ctrl[MRD_UDP_BIT] && is_ip &&
                st.proto == MRD_PROTO_UDP && !zero &&
                !sum_ok(lsum + pseudo)) begin
               bad = 1'b1;
            end
            next_st.frame_done = 1'b1;
            next_st.frame_drop = bad;
            if (bad) begin
               next_st.drop_cnt = st.drop_cnt + 16'h0001;
            end
         end
      end

      // run state: a stop waits for the frame in progress
      case (st.run_st)
         MRD_ST_STOP: begin
            if (st.ctrl[MRD_RUN_BIT]) begin
               next_st.run_st = MRD_ST_RUN;
            end
         end
         MRD_ST_RUN: begin
            if (!st.ctrl[MRD_RUN_BIT]) begin
               next_st.run_st = next_st.in_frame ? MRD_ST_DRAIN
                  : MRD_ST_STOP;
            end
         end
         MRD_ST_DRAIN: begin
            if (st.ctrl[MRD_RUN_BIT]) begin
               next_st.run_st = MRD_ST_RUN;
            end else if (!next_st.in_frame) begin
               next_st.run_st = MRD_ST_STOP;
            end
         end
         default: next_st.run_st = MRD_ST_STOP;
      endcase

      // burst requests toward the bus while the receive side runs
      case (st.dma_st)
         MRD_DMA_IDLE: begin
            if (st.run_st != MRD_ST_STOP && buf_words != 11'h000) begin
               next_st.dma_st = MRD_DMA_BUSY;
               next_st.dma_req = 1'b1;
               next_st.dma_len = burst_len(
                  st.ctrl[MRD_BURST_HI:MRD_BURST_LO], buf_words);
            end
         end
         MRD_DMA_BUSY: begin
            if (dma_ack) begin
               next_st.dma_st = MRD_DMA_IDLE;
               next_st.dma_req = 1'b0;
            end
         end
         default: begin
            next_st.dma_st = MRD_DMA_IDLE;
            next_st.dma_req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.ctrl <= MRD_CTRL_RESET;
         st.run_st <= MRD_ST_STOP;
         st.dma_st <= MRD_DMA_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // pause frames only count in full duplex with the honour bit set
   mrd_pause_timer u_pause (
      .pclk(pclk),
      .presetn(presetn),
      .enable(st.ctrl[MRD_PAUSE_BIT] && full_duplex),
      .load(pause_valid),
      .quanta(pause_quanta),
      .hold(pause_hold)
   );

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign dma_req = st.dma_req;
   assign dma_len = st.dma_len;
   assign word_valid = st.word_valid;
   assign word_data = st.word_data;
   assign frame_done = st.frame_done;
   assign frame_drop = st.frame_drop;
   assign desc_shift = st.desc_shift;
   assign tx_hold = pause_hold;
endmodule

/* File: include/mrd_pkg.sv */
// mrd_pkg: register map, field positions and constants of the receive
// dma control block; shared by the block and its pause timer.
package mrd_pkg;
   localparam logic [7:0] MRD_CTRL_OFF = 8'h04;
   localparam logic [7:0] MRD_STAT_OFF = 8'h20;
   localparam logic [31:0] MRD_CTRL_RESET = 32'h0000_0000;
   // writable bits of rx_dma_control; reserved bits read as zero
   localparam logic [31:0] MRD_CTRL_WMASK = 32'h3f0f_0201;
   localparam int MRD_BURST_LO = 24;
   localparam int MRD_BURST_HI = 29;
   localparam int MRD_ALIGN_BIT = 19;
   localparam int MRD_UDP_BIT = 18;
   localparam int MRD_TCP_BIT = 17;
   localparam int MRD_IP_BIT = 16;
   localparam int MRD_PAUSE_BIT = 9;
   localparam int MRD_RUN_BIT = 0;
   localparam logic [15:0] MRD_ETH_IPV4 = 16'h0800;
   localparam logic [7:0] MRD_PROTO_TCP = 8'h06;
   localparam logic [7:0] MRD_PROTO_UDP = 8'h11;
   localparam logic [15:0] MRD_L2_LEN = 16'h000e;
   localparam logic [15:0] MRD_OFF_TYPE = 16'h000c;
   localparam logic [15:0] MRD_OFF_IHL = 16'h000e;
   localparam logic [15:0] MRD_OFF_TLEN = 16'h0010;
   localparam logic [15:0] MRD_OFF_PROTO = 16'h0017;
   localparam logic [15:0] MRD_OFF_SRC = 16'h001a;
   localparam logic [15:0] MRD_OFF_DST_END = 16'h0021;
   localparam logic [15:0] MRD_OFF_UDP_CK = 16'h0006;
   localparam logic [1:0] MRD_ALIGN_PAD = 2'h2;
   // one pause quantum is 512 bit times at 100 Mb/s
   localparam int MRD_QUANTUM_NS = 5120;
   localparam int MRD_CLK_NS = 10;
   localparam int MRD_QUANTUM_CYC = (MRD_QUANTUM_NS + MRD_CLK_NS - 1)
      / MRD_CLK_NS;
   typedef enum logic [2:0] {
      MRD_ST_STOP = 3'b001,
      MRD_ST_RUN = 3'b010,
      MRD_ST_DRAIN = 3'b100
   } mrd_run_e;
   typedef enum logic [1:0] {
      MRD_DMA_IDLE = 2'b01,
      MRD_DMA_BUSY = 2'b10
   } mrd_dma_e;
endpackage

/* File: design/mrd_pause_timer.sv */
// mrd_pause_timer: holds transmission for a number of pause quanta.
// assumes load is a one-cycle pulse from the receive control block.
`timescale 1ns/1ps
module mrd_pause_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic load,
   input wire logic [15:0] quanta,
   output logic hold
);
   import mrd_pkg::*;
   localparam logic [9:0] LAST_CYC = 10'(MRD_QUANTUM_CYC - 1);
   typedef struct packed {
      logic hold;
      logic [15:0] left;
      logic [9:0] sub;
   } mrd_pt_s;
   mrd_pt_s st;
   mrd_pt_s next_st;

   always_comb begin
      next_st = st;
      if (!enable) begin
         next_st.hold = 1'b0;
      end else if (load) begin
         // a new pause frame restarts the count; zero ends a pause
         next_st.left = quanta;
         next_st.sub = 10'h000;
         next_st.hold = (quanta != 16'h0000);
      end else if (st.hold) begin
         if (st.sub == LAST_CYC) begin
            next_st.sub = 10'h000;
            next_st.left = st.left - 16'h0001;
            if (st.left == 16'h0001) begin
               next_st.hold = 1'b0;
            end
         end else begin
            next_st.sub = st.sub + 10'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign hold = st.hold;
endmodule

/* File: testbench/mrd_dma_partner.sv */
// mrd_dma_partner: bus side of the receive dma, answers burst requests.
// assumes dma_req is held until dma_ack, as the block promises.
`timescale 1ns/1ps
module mrd_dma_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic dma_req,
   output logic dma_ack
);
   logic [3:0] waited;
   // a slow bus leaves the request pending for several cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waited <= 4'h0;
         dma_ack <= 1'b0;
      end else if (dma_ack || !dma_req) begin
         waited <= 4'h0;
         dma_ack <= 1'b0;
      end else begin
         waited <= waited + 4'h1;
         dma_ack <= waited == (slow ? 4'h6 : 4'h0);
      end
   end
endmodule

/* File: testbench/mrd_rx_control_properties.sv */
// mrd_props: port-level assertions for mrd_rx_control.
// assumes apb writes complete one wait cycle after the access phase.
`timescale 1ns/1ps
module mrd_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic full_duplex,
   input wire logic pause_valid,
   input wire logic [15:0] pause_quanta,
   input wire logic [10:0] buf_words,
   input wire logic dma_ack,
   input wire logic dma_req,
   input wire logic [10:0] dma_len,
   input wire logic word_valid,
   input wire logic frame_done,
   input wire logic frame_drop,
   input wire logic [1:0] desc_shift,
   input wire logic tx_hold
);
   import mrd_pkg::*;
   logic [31:0] ctl;
   logic run_seen;
   // shadow of the control register, updated where the write lands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= 32'h0;
         run_seen <= 1'b0;
      end else begin
         run_seen <= run_seen | ctl[MRD_RUN_BIT];
         if (psel && penable && pready && pwrite && paddr == MRD_CTRL_OFF)
            ctl <= pwdata & MRD_CTRL_WMASK;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_grant; dma_req && dma_ack; endsequence
   a_one_wait: assert property (s_wait |=> pready)
      else $error("apb access not answered after one wait");
   a_read_back: assert property (pready && !pwrite && paddr == MRD_CTRL_OFF
      |-> prdata == ctl)
      else $error("control register read differs from writes");
   a_burst_cap: assert property (dma_req && ctl[29:24] != 6'h0
      |-> dma_len <= 11'(ctl[29:24]))
      else $error("burst longer than burst field");
   a_burst_zero: assert property ($rose(dma_req) && ctl[29:24] == 6'h0
      |-> dma_len == $past(buf_words))
      else $error("unlimited burst not sized by buffer");
   a_req_hold: assert property (dma_req && !dma_ack
      |=> dma_req && $stable(dma_len))
      else $error("burst request changed before ack");
   a_req_drop: assert property (s_grant |=> !dma_req)
      else $error("burst request stayed after ack");
   a_idle_stop: assert property (!run_seen && !ctl[0]
      |-> !dma_req && !word_valid)
      else $error("dma active before run");
   a_pause_on: assert property (pause_valid && ctl[9] && full_duplex
      && pause_quanta != 16'h0 |=> tx_hold)
      else $error("pause frame not honoured");
   a_pause_off: assert property ((!ctl[9] || !full_duplex) [*2]
      |-> !tx_hold)
      else $error("transmit held while pause disabled");
   a_drop_done: assert property (frame_drop |-> frame_done)
      else $error("drop without frame end");
   a_shift_value: assert property (frame_done
      |-> desc_shift == (ctl[19] ? 2'h2 : 2'h0))
      else $error("header shift wrong");
endmodule
bind mrd_rx_control mrd_props u_props (.*);

/* File: testbench/mac_rx_dma_control_test.sv */
// mac_rx_dma_control_test: self-checking bench of mrd_rx_control.
// assumes mrd_dma_partner answers bursts and the checker is bound in.
`timescale 1ns/1ps
module mac_rx_dma_control_test;
   import mrd_pkg::*;
   typedef struct {
      logic [31:0] ctl;
      logic [10:0] buf_n;
      logic [10:0] len;
      logic [7:0] proto;
      logic bad_ip;
      logic bad_l4;
      logic drop;
   } mrd_row_s;
   // burst values cover zero and each power of two up to 32; ff marks a non-ip frame
   mrd_row_s rows [9] = '{
      '{32'h0000_0001, 11'h5, 11'h5, MRD_PROTO_UDP, 1'b0, 1'b1, 1'b0},
      '{32'h0404_0001, 11'h5, 11'h4, MRD_PROTO_UDP, 1'b0, 1'b1, 1'b1},
      '{32'h0102_0001, 11'h3, 11'h1, MRD_PROTO_TCP, 1'b0, 1'b1, 1'b1},
      '{32'h200c_0001, 11'h28, 11'h20, MRD_PROTO_TCP, 1'b0, 1'b1, 1'b0},
      '{32'h1001_0001, 11'h7, 11'h7, MRD_PROTO_UDP, 1'b1, 1'b0, 1'b1},
      '{32'h0207_0001, 11'h9, 11'h2, 8'h01, 1'b0, 1'b1, 1'b0},
      '{32'h0807_0001, 11'h8, 11'h8, MRD_PROTO_UDP, 1'b0, 1'b0, 1'b0},
      '{32'h000b_0001, 11'h2, 11'h2, MRD_PROTO_TCP, 1'b1, 1'b0, 1'b1},
      '{32'h0007_0001, 11'h1, 11'h1, 8'hff, 1'b1, 1'b1, 1'b0}};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, rx_valid, rx_last;
   logic full_duplex, pause_valid, dma_ack, dma_req, word_valid, slow;
   logic frame_done, frame_drop, tx_hold, err, got_drop;
   logic [7:0] paddr, rx_byte;
   logic [15:0] pause_quanta;
   logic [10:0] buf_words, dma_len;
   logic [31:0] pwdata, prdata, word_data, rd, first_word;
   logic [1:0] desc_shift, got_shift, sh;
   logic [7:0] frame [0:53];
   int n_fail = 0;
   int num_checks = 0;
   int n_words, n_done, n_hold;
   mrd_rx_control u_dut (.*);
   mrd_dma_partner u_partner (.*);
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (word_valid === 1'b1) begin
         if (n_words == 0) first_word = word_data;
         n_words++;
      end
      if (frame_done === 1'b1) begin
         n_done++;
         got_drop = frame_drop;
         got_shift = desc_shift;
      end
      if (tx_hold === 1'b1) n_hold++;
   end
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      check("pready", 32'h1, 32'(pready));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_req(input logic v);
      int n;
      n = 0;
      while (dma_req !== v && n < 50) begin
         @(posedge pclk);
         n++;
      end
      check("dma_req", 32'(v), 32'(dma_req));
   endtask
   function automatic logic [15:0] ocsum(input int from, input int n,
      input logic [31:0] init);
      logic [31:0] s;
      s = init;
      for (int i = from; i < from + n; i += 2) s += {frame[i], frame[i + 1]};
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      return ~s[15:0];
   endfunction
   // 54-byte ipv4 frame (non-ip type for proto ff), 20-byte l4 header, checksums optionally spoiled
   task automatic build(input logic [7:0] proto, input logic bad_ip,
      input logic bad_l4);
      int at;
      logic [31:0] ps;
      at = (proto == MRD_PROTO_UDP) ? 40 : 50;
      for (int i = 0; i < 54; i++) frame[i] = 8'(i * 7 + 3);
      {frame[12], frame[13]} = (proto == 8'hff) ? 16'h86dd : MRD_ETH_IPV4;
      {frame[14], frame[16], frame[17], frame[23]} = {8'h45, 16'h28, proto};
      {frame[24], frame[25], frame[at], frame[at + 1]} = 32'h0;
      {frame[38], frame[39]} = 16'h0014;
      {frame[24], frame[25]} = ocsum(14, 20, 32'h0) ^ {15'h0, bad_ip};
      ps = {16'h0, ~ocsum(26, 8, 32'h0)} + {24'h0, proto} + 32'h14;
      {frame[at], frame[at + 1]} = ocsum(34, 20, ps) ^ {15'h0, bad_l4};
   endtask
   task automatic send_frame();
      for (int i = 0; i < 54; i++) begin
         @(posedge pclk);
         rx_valid <= 1'b1;
         rx_byte <= frame[i];
         rx_last <= (i == 53);
      end
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic pulse(input logic [15:0] q);
      @(posedge pclk);
      pause_valid <= 1'b1;
      pause_quanta <= q;
      @(posedge pclk);
      pause_valid <= 1'b0;
      n_hold = 0;
   endtask
   initial begin
      // whole run is near 1500 cycles
      repeat (20000) @(posedge pclk);
      n_fail++;
      finish_test();
   end
   initial begin
      {psel, penable, pwrite, rx_valid, rx_last, pause_valid, slow} = 7'h0;
      {paddr, rx_byte, pause_quanta, buf_words, pwdata} = 75'h0;
      full_duplex = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, MRD_CTRL_OFF, 32'h0, rd);
      check("ctl reset", MRD_CTRL_RESET, rd);
      apb(1'b1, MRD_CTRL_OFF, 32'he0ff_fffe, rd);
      apb(1'b0, MRD_CTRL_OFF, 32'h0, rd);
      check("ctl mask", 32'h200f_0200, rd);
      apb(1'b0, 8'h10, 32'h0, rd);
      check("unmapped", 32'h1, {rd[30:0], err});
      $display("test registers done");
      foreach (rows[r]) begin
         slow <= r[0];
         build(rows[r].proto, rows[r].bad_ip, rows[r].bad_l4);
         apb(1'b1, MRD_CTRL_OFF, rows[r].ctl, rd);
         buf_words <= rows[r].buf_n;
         wait_req(1'b1);
         buf_words <= 11'h0;
         check("burst len", 32'(rows[r].len), 32'(dma_len));
         wait_req(1'b0);
         sh = rows[r].ctl[MRD_ALIGN_BIT] ? 2'h2 : 2'h0;
         n_done = 0;
         n_words = 0;
         send_frame();
         check("done", 32'h1, 32'(n_done));
         check("drop", 32'(rows[r].drop), 32'(got_drop));
         check("shift", 32'(sh), 32'(got_shift));
         check("lane", 32'(frame[0]), 32'(8'(first_word >> (8 * sh))));
         $display("test row %0d done", r);
      end
      apb(1'b1, MRD_CTRL_OFF, 32'h0000_0201, rd);
      pulse(16'h1);
      repeat (600) @(posedge pclk);
      check("hold cycles", 32'h200, 32'(n_hold));
      apb(1'b1, MRD_CTRL_OFF, 32'h0000_0001, rd);
      for (int k = 0; k < 2; k++) begin
         full_duplex <= (k == 0);
         pulse(16'h3);
         repeat (20) @(posedge pclk);
         check("no hold", 32'h0, 32'(n_hold));
      end
      $display("test pause done");
      full_duplex <= 1'b1;
      build(MRD_PROTO_UDP, 1'b0, 1'b0);
      n_done = 0;
      n_words = 0;
      fork
         send_frame();
         begin
            repeat (10) @(posedge pclk);
            apb(1'b1, MRD_CTRL_OFF, 32'h0, rd);
         end
      join
      check("drain done", 32'h1, 32'(n_done));
      check("drain words", 32'he, 32'(n_words));
      send_frame();
      check("stopped frame", 32'h1, 32'(n_done));
      check("stopped words", 32'he, 32'(n_words));
      buf_words <= 11'h5;
      repeat (20) @(posedge pclk);
      check("stopped req", 32'h0, 32'(dma_req));
      $display("test stop done");
      // four rows above expect a drop; run state must read stopped
      apb(1'b0, MRD_STAT_OFF, 32'h0, rd);
      check("status", 32'h0004_0001, rd);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, MRD_STAT_OFF, 32'h0, rd);
      check("status reset", 32'h0000_0001, rd);
      apb(1'b0, MRD_CTRL_OFF, 32'h0, rd);
      check("ctl reset again", MRD_CTRL_RESET, rd);
      $display("test reset done");
      finish_test();
   end
endmodule
